// *** logic/sirq_map.svh ***
// constants of the serialized interrupt link: offsets, fields, resets and counts
// What this block does
// (R1) quiet idle: slave pulls low one clock, releases
// (R2) no slave start during an active cycle
// (R3) host holds start low 4-8 clocks, high, releases
// (R4) quiet mode: level change triggers a slave start
// (R5) continuous mode: only the host starts cycles
// (R6) host stop: 2 lows quiet, 3 lows continuous
// (R7) reset selects continuous mode; host runs first cycle
// (R8) frames count from start rise, three clocks each
// (R9) sample clock: drive low only for low level
// (R10) recovery clock: drive high after own sample low
// (R11) turnaround clock: release the wire
// (R12) frame n sample at clock 3n-1, slots 1-15
// (R13) report low levels whoever started the cycle
// (R14) enable bit 6 to frame, bit 7 to pin
// (R15) quiet start not before second clock after stop
// (R16) wire released while bus reset is active
// (R17) drive and sample on rising clock edge only
// (R18) host runs initial cycle, continuous before reconfiguration
// (R19) four-bit slot selector per external input, zero off
// (R20) enabled internal source blocks external on shared slot
// (R21) no-enable sources count enabled when active, numbered
// (R22) host delays end-of-interrupt by cycle latency; the host has no end-of-interrupt, only levels_valid after the stop
`ifndef SIRQ_MAP_SVH
`define SIRQ_MAP_SVH

// ***********************************************
// configuration registers
// ***********************************************
`define SIRQ_OFS_SLOT_LO   8'hF4
`define SIRQ_OFS_SLOT_HI   8'hF5
`define SIRQ_RST_SLOT      8'h00
`define SIRQ_MGMT_FRM_BIT  6
`define SIRQ_MGMT_PIN_BIT  7

// ***********************************************
// framing
// ***********************************************
`define SIRQ_NSRC          8
`define SIRQ_NEXT          4
`define SIRQ_MGMT_SLOT     2
`define SIRQ_FIRST_FRAME   5'h02
`define SIRQ_LAST_FRAME    5'h10
`define SIRQ_HOST_FRAMES   5'h11
`define SIRQ_STOP_QUIET    4'h2
`define SIRQ_STOP_CONT     4'h3
`define SIRQ_START_W_MIN   3'h3

`endif

// *** logic/sirq_pkg.sv ***
// types shared by both ends of the serialized interrupt link
package sirq_pkg;

  // slave link state
  typedef enum logic [1:0] {
    D_IDLE   = 2'b00,
    D_START  = 2'b01,
    D_FRAMES = 2'b10,
    D_STOP   = 2'b11
  } sirq_dst_t;

  // host link state
  typedef enum logic [2:0] {
    H_IDLE     = 3'b000,
    H_START    = 3'b001,
    H_START_HI = 3'b010,
    H_FRAMES   = 3'b011,
    H_STOP     = 3'b100,
    H_STOP_HI  = 3'b101
  } sirq_hst_t;

  // phase inside one data frame
  typedef enum logic [1:0] {
    PH_SAMP = 2'b00,
    PH_REC  = 2'b01,
    PH_TURN = 2'b10
  } sirq_phase_t;

  // cycle mode chosen by the stop pulse
  typedef enum logic {
    MODE_CONT  = 1'b0,
    MODE_QUIET = 1'b1
  } sirq_mode_t;

endpackage

// *** logic/sirq_if.sv ***
// shared serialized interrupt wire joining the slave and host ends
`timescale 1ns/1ps
interface sirq_if;
  logic dev_drv;
  logic dev_oe_n;
  logic host_drv;
  logic host_oe_n;
  logic wire_lvl;

  // pulled up; any enabled low driver pulls it low
  assign wire_lvl = !((!dev_oe_n && !dev_drv) || (!host_oe_n && !host_drv));

  modport dev  (output dev_drv, output dev_oe_n, input wire_lvl);
  modport host (output host_drv, output host_oe_n, input wire_lvl);
endinterface

// *** logic/sirq_dev.sv ***
// slave end: serializes internal and routed external interrupt levels
`timescale 1ns/1ps
`include "sirq_map.svh"
module sirq_dev
  import sirq_pkg::*;
(
  // clock and bus reset
  input  wire logic                          mclk,
  input  wire logic                          reset,
  // serialized interrupt wire
  sirq_if.dev                                sw,
  // configuration port
  input  wire logic                          cfg_wr_en,
  input  wire logic [7:0]                    cfg_addr,
  input  wire logic [7:0]                    cfg_wdata,
  output logic      [7:0]                    cfg_rdata,
  // internal function sources
  input  wire logic [`SIRQ_NSRC-1:0]         src_level,
  input  wire logic [`SIRQ_NSRC-1:0]         src_active,
  input  wire logic [`SIRQ_NSRC-1:0]         src_has_en,
  input  wire logic [`SIRQ_NSRC-1:0]         src_en,
  input  wire logic [4*`SIRQ_NSRC-1:0]       src_sel,
  // external interrupt pins
  input  wire logic                          ext_irq_input_a,
  input  wire logic                          ext_irq_input_b,
  input  wire logic                          ext_irq_input_c,
  input  wire logic                          ext_irq_input_d,
  // management interrupt
  input  wire logic                          mgmt_interrupt_n,
  input  wire logic [7:0]                    mgmt_enable2,
  output logic                               mgmt_interrupt_pin_n,
  // status
  output logic                               quiet_mode
);

  // ***********************************************
  // declarations
  // ***********************************************
  logic [7:0]            slot_lo_reg;
  logic [7:0]            slot_hi_reg;
  logic [`SIRQ_NEXT-1:0] ext_s1_reg;
  logic [`SIRQ_NEXT-1:0] ext_s2_reg;
  logic [`SIRQ_NEXT-1:0] ext_s3_reg;
  logic [`SIRQ_NEXT-1:0] ext_f_reg;
  logic [`SIRQ_NEXT-1:0] ext_raw;
  logic [15:0]           ext_sel_all;
  logic [`SIRQ_NSRC-1:0] int_en;
  logic [15:0]           slot_level;
  logic [15:0]           reported_reg;
  logic                  pending;
  sirq_dst_t             state_reg;
  sirq_phase_t           phase_reg;
  sirq_phase_t           phase_next;
  logic [4:0]            frame_reg;
  logic [4:0]            frame_next;
  logic [3:0]            low_run_reg;
  sirq_mode_t            mode_reg;
  logic                  wire_hi;
  logic                  frame_run;
  logic                  slot_frame;
  logic                  start_go;
  logic                  drv_reg;
  logic                  oe_n_reg;

  assign wire_hi     = sw.wire_lvl;  // sampled on the rising edge only [R17]
  assign ext_raw     = {ext_irq_input_d, ext_irq_input_c, ext_irq_input_b, ext_irq_input_a};
  assign ext_sel_all = {slot_hi_reg, slot_lo_reg};
  assign sw.dev_drv  = drv_reg;
  assign sw.dev_oe_n = oe_n_reg;
  assign quiet_mode  = (mode_reg == MODE_QUIET);

  // ***********************************************
  // external pin synchronisers
  // ***********************************************
  // three stages; filtered level moves only when stages two and three agree
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      ext_s1_reg <= 4'hF;
      ext_s2_reg <= 4'hF;
      ext_s3_reg <= 4'hF;
      ext_f_reg  <= 4'hF;
    end else begin
      ext_s1_reg <= ext_raw;
      ext_s2_reg <= ext_s1_reg;
      ext_s3_reg <= ext_s2_reg;
      ext_f_reg  <= (ext_s2_reg & ext_s3_reg) | (ext_f_reg & (ext_s2_reg ^ ext_s3_reg));
    end
  end

  // ***********************************************
  // configuration registers
  // ***********************************************
  // slot selectors: low byte inputs a/b, high byte inputs c/d
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      slot_lo_reg <= `SIRQ_RST_SLOT;
      slot_hi_reg <= `SIRQ_RST_SLOT;
    end else if (cfg_wr_en) begin
      if (cfg_addr == `SIRQ_OFS_SLOT_LO) slot_lo_reg <= cfg_wdata;
      if (cfg_addr == `SIRQ_OFS_SLOT_HI) slot_hi_reg <= cfg_wdata;
    end
  end

  // registered read data; other addresses read zero
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      cfg_rdata <= 8'h00;
    end else if (cfg_addr == `SIRQ_OFS_SLOT_LO) begin
      cfg_rdata <= slot_lo_reg;
    end else if (cfg_addr == `SIRQ_OFS_SLOT_HI) begin
      cfg_rdata <= slot_hi_reg;
    end else begin
      cfg_rdata <= 8'h00;
    end
  end

  // management pin gated by its enable bit
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      mgmt_interrupt_pin_n <= 1'b1;
    end else begin
      mgmt_interrupt_pin_n <= mgmt_interrupt_n | ~mgmt_enable2[`SIRQ_MGMT_PIN_BIT];  // [R14]
    end
  end

  // ***********************************************
  // slot level merge
  // ***********************************************
  // a source counts when active, numbered, and enabled if it has an enable
  genvar gk;
  generate
    for (gk = 0; gk < `SIRQ_NSRC; gk++) begin : g_en
      assign int_en[gk] = src_active[gk] && (src_sel[4*gk +: 4] != 4'h0)
                          && (!src_has_en[gk] || src_en[gk]);  // [R20] [R21]
    end
  endgenerate

  assign slot_level[0] = 1'b1;

  // per slot: internal owners win, else routed external pins
  genvar gs;
  generate
    for (gs = 1; gs < 16; gs++) begin : g_slot
      logic lvl;
      always_comb begin
        logic claim;
        logic int_low;
        logic ext_low;
        logic mgmt_low;
        claim    = 1'b0;
        int_low  = 1'b0;
        ext_low  = 1'b0;
        mgmt_low = 1'b0;
        for (int k = 0; k < `SIRQ_NSRC; k++) begin
          if (int_en[k] && (src_sel[4*k +: 4] == 4'(gs))) begin
            claim = 1'b1;  // [R20]
            if (!src_level[k]) int_low = 1'b1;
          end
        end
        for (int e = 0; e < `SIRQ_NEXT; e++) begin
          if ((ext_sel_all[4*e +: 4] == 4'(gs)) && !ext_f_reg[e]) ext_low = 1'b1;  // [R19]
        end
        mgmt_low = (gs == `SIRQ_MGMT_SLOT) && mgmt_enable2[`SIRQ_MGMT_FRM_BIT]
                   && !mgmt_interrupt_n;  // [R14]
        lvl = !((claim ? int_low : ext_low) || mgmt_low);
      end
      assign slot_level[gs] = lvl;  // one driver per slot bit
    end
  endgenerate

  // a level not yet delivered since its last report
  assign pending = |(slot_level ^ reported_reg);

  // ***********************************************
  // frame sequencing
  // ***********************************************
  // frames start from the start pulse rise; phases rotate every clock
  always_comb begin
    phase_next = PH_TURN;
    frame_next = frame_reg;
    if (state_reg == D_START) begin
      phase_next = PH_TURN;  // clock one after the rise [R8]
      frame_next = 5'h00;
    end else begin
      unique case (phase_reg)
        PH_TURN: begin
          phase_next = PH_SAMP;
          if (frame_reg != `SIRQ_HOST_FRAMES) frame_next = frame_reg + 5'h01;
        end
        PH_SAMP: phase_next = PH_REC;
        PH_REC:  phase_next = PH_TURN;
        default: phase_next = PH_TURN;
      endcase
    end
  end

  assign frame_run  = (state_reg == D_FRAMES) || ((state_reg == D_START) && wire_hi);
  assign slot_frame = (frame_next >= `SIRQ_FIRST_FRAME) && (frame_next <= `SIRQ_LAST_FRAME);

  // quiet, idle, wire high and something to tell
  assign start_go = (state_reg == D_IDLE) && (mode_reg == MODE_QUIET) && wire_hi
                    && pending;  // [R1] [R2] [R4] [R5] [R15]

  // link state, counters and mode
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      state_reg   <= D_IDLE;
      phase_reg   <= PH_TURN;
      frame_reg   <= 5'h00;
      low_run_reg <= 4'h0;
      mode_reg    <= MODE_CONT;  // [R7]
    end else begin
      low_run_reg <= wire_hi ? 4'h0 : (low_run_reg == 4'hF ? 4'hF : low_run_reg + 4'h1);
      if (frame_run) begin
        phase_reg <= phase_next;
        frame_reg <= frame_next;
      end
      unique case (state_reg)
        D_IDLE: begin
          if (start_go || !wire_hi) state_reg <= D_START;
        end
        D_START: begin
          if (wire_hi) state_reg <= D_FRAMES;  // [R8]
        end
        D_FRAMES: begin
          if (!wire_hi && low_run_reg != 4'h0) state_reg <= D_STOP;
        end
        D_STOP: begin
          if (wire_hi) begin
            state_reg <= D_IDLE;
            mode_reg  <= (low_run_reg == `SIRQ_STOP_QUIET) ? MODE_QUIET : MODE_CONT;  // [R6]
          end
        end
      endcase
    end
  end

  // ***********************************************
  // wire drive and delivered levels
  // ***********************************************
  // start pulse, sample low, recovery high, otherwise released
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      drv_reg  <= 1'b1;
      oe_n_reg <= 1'b1;  // [R16]
    end else if (start_go) begin
      drv_reg  <= 1'b0;  // one clock low, never high [R1]
      oe_n_reg <= 1'b0;
    end else if (frame_run && phase_next == PH_SAMP && slot_frame
                 && !slot_level[frame_next[3:0] - 4'h1]) begin
      drv_reg  <= 1'b0;  // [R9] [R12] [R13]
      oe_n_reg <= 1'b0;
    end else if (frame_run && phase_next == PH_REC && !oe_n_reg && !drv_reg) begin
      drv_reg  <= 1'b1;  // [R10]
      oe_n_reg <= 1'b0;
    end else begin
      drv_reg  <= 1'b1;  // [R11]
      oe_n_reg <= 1'b1;
    end
  end

  // remember what each slot last reported
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      reported_reg <= 16'hFFFF;
    end else if (frame_run && phase_next == PH_SAMP && slot_frame) begin
      reported_reg[frame_next[3:0] - 4'h1] <= slot_level[frame_next[3:0] - 4'h1];  // [R4]
    end
  end

endmodule

// *** logic/sirq_host.sv ***
// host end: runs start and stop frames and collects slot levels
`timescale 1ns/1ps
`include "sirq_map.svh"
module sirq_host
  import sirq_pkg::*;
(
  // clock and bus reset
  input  wire logic        mclk,
  input  wire logic        reset,
  // serialized interrupt wire
  sirq_if.host             sw,
  // user control
  input  wire logic        run,
  input  wire logic        quiet_sel,
  input  wire logic [2:0]  start_width,
  // collected levels
  output logic      [15:0] irq_levels,
  output logic             levels_valid,
  output logic             busy
);

  // ***********************************************
  // declarations
  // ***********************************************
  sirq_hst_t   state_reg;
  sirq_phase_t phase_reg;
  logic [4:0]  frame_reg;
  logic [2:0]  left_reg;
  logic [2:0]  width;
  sirq_mode_t  mode_reg;
  logic        drv_reg;
  logic        oe_n_reg;
  logic        wire_hi;

  assign wire_hi      = sw.wire_lvl;  // [R17]
  assign sw.host_drv  = drv_reg;
  assign sw.host_oe_n = oe_n_reg;
  assign busy         = (state_reg != H_IDLE);
  assign width        = (start_width < `SIRQ_START_W_MIN) ? `SIRQ_START_W_MIN : start_width;

  // ***********************************************
  // cycle sequencer
  // ***********************************************
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      state_reg <= H_IDLE;
      phase_reg <= PH_TURN;
      frame_reg <= 5'h00;
      left_reg  <= 3'h0;
      mode_reg  <= MODE_CONT;  // [R7]
      drv_reg   <= 1'b1;
      oe_n_reg  <= 1'b1;  // [R16]
    end else begin
      unique case (state_reg)
        H_IDLE: begin
          if (run) begin
            state_reg <= H_START;  // first cycle only from run [R5] [R18]
            left_reg  <= width;
            drv_reg   <= 1'b0;
            oe_n_reg  <= 1'b0;
          end else if (mode_reg == MODE_QUIET && !wire_hi) begin
            state_reg <= H_START;  // take over a slave start [R3]
            left_reg  <= width - 3'h1;
            drv_reg   <= 1'b0;
            oe_n_reg  <= 1'b0;
          end
        end
        H_START: begin
          if (left_reg == 3'h0) begin
            state_reg <= H_START_HI;
            drv_reg   <= 1'b1;  // [R3]
          end else begin
            left_reg <= left_reg - 3'h1;
          end
        end
        H_START_HI: begin
          state_reg <= H_FRAMES;
          oe_n_reg  <= 1'b1;
          phase_reg <= PH_TURN;
          frame_reg <= 5'h00;
        end
        H_FRAMES: begin
          unique case (phase_reg)
            PH_TURN: begin
              if (frame_reg == `SIRQ_HOST_FRAMES) begin
                state_reg <= H_STOP;  // [R6]
                left_reg  <= quiet_sel ? 3'(`SIRQ_STOP_QUIET - 4'h1) : 3'(`SIRQ_STOP_CONT - 4'h1);
                mode_reg  <= quiet_sel ? MODE_QUIET : MODE_CONT;
                drv_reg   <= 1'b0;
                oe_n_reg  <= 1'b0;
              end else begin
                phase_reg <= PH_SAMP;
                frame_reg <= frame_reg + 5'h01;
              end
            end
            PH_SAMP: phase_reg <= PH_REC;
            PH_REC:  phase_reg <= PH_TURN;
            default: phase_reg <= PH_TURN;
          endcase
        end
        H_STOP: begin
          if (left_reg == 3'h0) begin  // two or three low clocks in all [R6]
            state_reg <= H_STOP_HI;
            drv_reg   <= 1'b1;
          end else begin
            left_reg <= left_reg - 3'h1;
          end
        end
        H_STOP_HI: begin
          state_reg <= H_IDLE;
          oe_n_reg  <= 1'b1;
        end
        default: state_reg <= H_IDLE;
      endcase
    end
  end

  // ***********************************************
  // level capture
  // ***********************************************
  // sample clock of frames 2..16 gives slots 1..15
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      irq_levels   <= 16'hFFFF;
      levels_valid <= 1'b0;
    end else begin
      levels_valid <= (state_reg == H_STOP_HI);  // handed on after the whole cycle [R22]
      if (state_reg == H_FRAMES && phase_reg == PH_SAMP
          && frame_reg >= `SIRQ_FIRST_FRAME && frame_reg <= `SIRQ_LAST_FRAME) begin
        irq_levels[frame_reg[3:0] - 4'h1] <= wire_hi;
      end
    end
  end

endmodule

// *** verification/sirq_sva.sv ***
// concurrent checks on the shared serialized interrupt wire
`timescale 1ns/1ps
module sirq_sva (
  // clock and bus reset
  input wire logic mclk,
  input wire logic reset,
  // wire drivers and resolved level
  input wire logic dev_drv,
  input wire logic dev_oe_n,
  input wire logic host_drv,
  input wire logic host_oe_n,
  input wire logic wire_lvl
);
  logic [3:0] lo_cnt_reg;
  logic       seen_reg;
  wire        dev_low = !dev_oe_n && !dev_drv;
  wire        dev_hi  = !dev_oe_n && dev_drv;
  wire        host_hi = !host_oe_n && host_drv;

  // length of the current low run on the wire
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      lo_cnt_reg <= 4'h0;
    end else if (wire_lvl) begin
      lo_cnt_reg <= 4'h0;
    end else if (lo_cnt_reg != 4'hF) begin
      lo_cnt_reg <= lo_cnt_reg + 4'h1;
    end
  end

  // host has driven the wire since reset
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      seen_reg <= 1'b0;
    end else if (!host_oe_n) begin
      seen_reg <= 1'b1;
    end
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (reset);

  sequence s_start;
    dev_low ##1 (!host_oe_n && !host_drv);
  endsequence
  sequence s_samp_rec;
    dev_low ##1 dev_hi;
  endsequence

  property p_rst_rel;   $fell(reset) |-> $past(dev_oe_n) && $past(host_oe_n); endproperty
  property p_start_rel; s_start |-> dev_oe_n; endproperty
  property p_rec_hi;    dev_hi |-> $past(dev_low); endproperty
  property p_turn_rel;  s_samp_rec |=> dev_oe_n; endproperty
  property p_frame_gap; dev_low |=> !dev_low [*2]; endproperty
  property p_stop_wait; host_hi |=> !dev_low; endproperty
  property p_low_run;   !wire_lvl |-> lo_cnt_reg < 4'h8; endproperty
  property p_cont_rst;  !seen_reg |-> dev_oe_n; endproperty
  property p_host_rel;  host_hi |=> host_oe_n; endproperty

  a_rst_rel:   assert property (p_rst_rel) else $error("wire driven during reset");
  a_start_rel: assert property (p_start_rel) else $error("start not released");
  a_rec_hi:    assert property (p_rec_hi) else $error("recovery high without sample");
  a_turn_rel:  assert property (p_turn_rel) else $error("turnaround not released");
  a_frame_gap: assert property (p_frame_gap) else $error("frames closer than three");
  a_stop_wait: assert property (p_stop_wait) else $error("slave low after high clock");
  a_low_run:   assert property (p_low_run) else $error("low pulse above eight");
  a_cont_rst:  assert property (p_cont_rst) else $error("slave drove before host");
  a_host_rel:  assert property (p_host_rel) else $error("host high not released");
endmodule

// *** verification/serial_irq_slave_serializer_tb.sv ***
// self-checking bench joining slave and host ends of the link
`timescale 1ns/1ps
module serial_irq_slave_serializer_tb;
  logic        mclk = 1'b0, reset = 1'b1, cfg_wr_en = 1'b0, mgmt_n = 1'b1, run = 1'b0;
  logic        quiet_sel = 1'b0, mgmt_pin_n, quiet_mode, levels_valid, busy;
  logic [7:0]  cfg_addr = 8'hF4, cfg_wdata = 8'h00, cfg_rdata, mgmt_en2 = 8'h00;
  logic [7:0]  src_level = 8'hFF, src_active = 8'h00, src_has_en = 8'h00, src_en = 8'h00;
  logic [31:0] src_sel = 32'h0, rnd = 32'h81356E48;
  logic [15:0] slot_v = 16'h0, irq_levels, nb;
  logic [3:0]  ext_lvl = 4'hF;
  logic [2:0]  start_width = 3'h3;
  int          err_total = 0, n_compared = 0, i;

  // clock and shared wire
  always #50 mclk = ~mclk;
  sirq_if sw();
  sirq_dev u_sirq_dev (.mclk(mclk), .reset(reset), .sw(sw), .cfg_wr_en(cfg_wr_en),
    .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
    .src_level(src_level), .src_active(src_active), .src_has_en(src_has_en),
    .src_en(src_en), .src_sel(src_sel), .ext_irq_input_a(ext_lvl[0]),
    .ext_irq_input_b(ext_lvl[1]), .ext_irq_input_c(ext_lvl[2]),
    .ext_irq_input_d(ext_lvl[3]), .mgmt_interrupt_n(mgmt_n), .mgmt_enable2(mgmt_en2),
    .mgmt_interrupt_pin_n(mgmt_pin_n), .quiet_mode(quiet_mode));
  sirq_host u_sirq_host (.mclk(mclk), .reset(reset), .sw(sw), .run(run),
    .quiet_sel(quiet_sel), .start_width(start_width), .irq_levels(irq_levels),
    .levels_valid(levels_valid), .busy(busy));
  sirq_sva u_sirq_sva (.mclk(mclk), .reset(reset), .dev_drv(sw.dev_drv),
    .dev_oe_n(sw.dev_oe_n), .host_drv(sw.host_drv), .host_oe_n(sw.host_oe_n),
    .wire_lvl(sw.wire_lvl));

  // xorshift step
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction

  // slot levels the host should collect
  function automatic logic [15:0] exp_lv();
    logic [15:0] lv, blk;
    logic [3:0]  s;
    lv = 16'hFFFF;
    blk = 16'h0000;
    for (int k = 0; k < 8; k++) begin
      s = src_sel[4*k +: 4];
      if (src_active[k] && (src_en[k] || !src_has_en[k]) && s != 4'h0) begin
        blk[s] = 1'b1;
        if (!src_level[k]) lv[s] = 1'b0;
      end
    end
    for (int k = 0; k < 4; k++) begin
      s = slot_v[4*k +: 4];
      if (s != 4'h0 && !blk[s] && !ext_lvl[k]) lv[s] = 1'b0;
    end
    if (mgmt_en2[6] && !mgmt_n) lv[2] = 1'b0;
    return lv;
  endfunction

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  // write both slot selectors back to back
  task automatic cfg_wr2(input logic [7:0] lo, input logic [7:0] hi);
    cfg_addr = 8'hF4;
    cfg_wdata = lo;
    cfg_wr_en = 1'b1;
    @(negedge mclk);
    cfg_addr = 8'hF5;
    cfg_wdata = hi;
    @(negedge mclk);
    cfg_wr_en = 1'b0;
    slot_v = {hi, lo};
  endtask

  task automatic cfg_rd(input logic [7:0] a, input logic [7:0] e);
    cfg_addr = a;
    @(negedge mclk);
    chk("cfg_rdata", {8'h00, e}, {8'h00, cfg_rdata});
  endtask

  // one link cycle, started by the host when go is set
  task automatic cyc(input logic go, input logic q, input logic [2:0] w);
    int n;
    quiet_sel = q;
    start_width = w;
    repeat (4) @(negedge mclk);
    run = go;
    @(negedge mclk);
    run = 1'b0;
    n = 0;
    while (levels_valid !== 1'b1 && n < 200) begin
      @(negedge mclk);
      n++;
    end
    chk("levels_valid", 16'h1, {15'h0, levels_valid});
  endtask

  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // watchdog
  initial begin
    repeat (20000) @(posedge mclk);
    err_total++;
    $display("Error watchdog expected finish seen timeout");
    end_sim();
  end

  // main sequence
  initial begin
    repeat (6) @(negedge mclk);
    chk("wire_lvl", 16'h1, {15'h0, sw.wire_lvl});
    repeat (6) @(negedge mclk);
    reset = 1'b0;
    @(negedge mclk);
    chk("quiet_mode", 16'h0, {15'h0, quiet_mode});
    chk("irq_levels", 16'hFFFF, irq_levels);
    chk("busy", 16'h0, {15'h0, busy});
    cfg_rd(8'hF4, 8'h00);
    for (i = 0; i < 8; i++) begin
      rnd = xs(rnd);
      {src_en, src_has_en, src_active, src_level} = rnd;
      rnd = xs(rnd);
      src_sel = rnd;
      rnd = xs(rnd);
      ext_lvl = rnd[3:0];
      mgmt_n = rnd[4];
      mgmt_en2 = rnd[15:8];
      if (i == 2 || i == 3) begin
        src_sel[3:0] = 4'h6;
        {src_active[0], src_has_en[0], src_en[0], src_level[0]} = {2'b11, i == 2, 1'b1};
        ext_lvl[0] = 1'b0;
        rnd[23:16] = 8'h06;
      end
      cfg_wr2(rnd[23:16], rnd[31:24]);
      cfg_rd(8'hF4, slot_v[7:0]);
      cfg_rd(8'hF5, slot_v[15:8]);
      cfg_rd(8'hF6, 8'h00);
      chk("mgmt_pin_n", {15'h0, mgmt_n | ~mgmt_en2[7]}, {15'h0, mgmt_pin_n});
      cyc(1'b1, 1'b0, (i == 0) ? 3'h3 : ((rnd[2:0] < 3'h3) ? 3'h7 : rnd[2:0]));
      chk("irq_levels", exp_lv(), irq_levels);
      chk("quiet_mode", 16'h0, {15'h0, quiet_mode});
    end
    src_active = 8'h00;
    cfg_wr2(8'h36, 8'h0F);
    cyc(1'b1, 1'b1, 3'h5);
    chk("quiet_mode", 16'h1, {15'h0, quiet_mode});
    ext_lvl[0] = ~ext_lvl[0];
    cyc(1'b0, 1'b1, 3'h5);
    chk("irq_levels", exp_lv(), irq_levels);
    cyc(1'b1, 1'b0, 3'h4);
    chk("quiet_mode", 16'h0, {15'h0, quiet_mode});
    ext_lvl[2] = ~ext_lvl[2];
    nb = 16'h0;
    repeat (150) begin
      @(negedge mclk);
      if (busy !== 1'b0 || sw.wire_lvl !== 1'b1) nb++;
    end
    chk("busy", 16'h0, nb);
    end_sim();
  end
endmodule
